// file: verilog/emw_top.sv
// Expanded memory window banking: APB register file plus window decode.
// Assumes CPU address and access strobe on clk_i, APB master on clk_i.
//
// What this block does
// [R1] Two-bit size per window, 00 disables
// [R2] Bank count shrinks as window grows
// [R3] Base bits 7:5 place window 2
// [R4] Base bits 3:1 place window 1
// [R5] 8K window starts on any 8K boundary
// [R6] 16K drops base LSB; 32K three bases
// [R7] Bank bits 6:1 drive lines 18:13
// [R8] Window hit drives its bank outward
// [R9] Bank bit needs pin assigned as expansion
// [R10] Software switches bank by writing register
// [R11] Window 1 wins where windows overlap
// [R12] 32K at 0x4000 inverts address 14
// [R13] Used low lines replace CPU address 15:13
// [R14] Unused low lines still carry CPU address
// [R15] Registers reset to zero, reserved ignored
// [R16] New values apply from next access
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "emw_defs.svh"
module emw_top (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_access_i,
  output logic      [15:0] cpu_addr_o,
  output logic      [5:0]  exp_addr_o,
  output logic      [5:0]  exp_line_en_o,
  output logic      [1:0]  window_hit_o,
  output logic             gpsel1_addr_follow_o,
  output logic             gpsel2_addr_follow_o
);
  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0]  size_q;
  logic [7:0]  base_q;
  logic [7:0]  bank1_q;
  logic [7:0]  bank2_q;
  logic [7:0]  pins_q;
  logic [1:0]  hit_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [15:0] cpu_addr_q;
  logic [5:0]  exp_addr_q;

  // ----------------------------------------------------------------------
  // APB address decode
  // ----------------------------------------------------------------------
  wire logic apb_acc  = psel_i & penable_i;
  wire logic sel_size = (paddr_i == `EMW_ADDR(`EMW_IDX_SIZE));
  wire logic sel_base = (paddr_i == `EMW_ADDR(`EMW_IDX_BASE));
  wire logic sel_bk1  = (paddr_i == `EMW_ADDR(`EMW_IDX_BANK1));
  wire logic sel_bk2  = (paddr_i == `EMW_ADDR(`EMW_IDX_BANK2));
  wire logic sel_pins = (paddr_i == `EMW_ADDR(`EMW_IDX_PINS));
  wire logic sel_stat = (paddr_i == `EMW_ADDR(`EMW_IDX_STAT));
  wire logic mapped   = sel_size | sel_base | sel_bk1 | sel_bk2 | sel_pins | sel_stat;
  // Write lands only on the edge where pready is seen high
  wire logic wr_fire  = apb_acc & pready_q & pwrite_i & mapped;
  wire logic [7:0] wdat = pwdata_i[7:0];

  // Read mux; reserved bits are never stored so they read zero
  wire logic [7:0] rd_mux = sel_size ? size_q  :
                            sel_base ? base_q  :
                            sel_bk1  ? bank1_q :
                            sel_bk2  ? bank2_q :
                            sel_pins ? pins_q  :
                            sel_stat ? {6'h00, hit_q} : 8'h00;

  // ----------------------------------------------------------------------
  // APB handshake: one wait state so outputs come from flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_acc & ~pready_q;
      pslverr_q <= apb_acc & ~pready_q & ~mapped;
      if (apb_acc & ~pready_q) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Window registers, masked so reserved bits stay zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      size_q  <= `EMW_RST_REG; // [R15]
      base_q  <= `EMW_RST_REG; // [R15]
      bank1_q <= `EMW_RST_REG; // [R15]
      bank2_q <= `EMW_RST_REG; // [R15]
      pins_q  <= `EMW_RST_REG;
    end else begin
      if (wr_fire & sel_size) size_q  <= wdat & `EMW_MASK_SIZE; // [R1]
      if (wr_fire & sel_base) base_q  <= wdat & `EMW_MASK_BASE; // [R3] [R4]
      if (wr_fire & sel_bk1)  bank1_q <= wdat & `EMW_MASK_BANK; // [R7] [R10]
      if (wr_fire & sel_bk2)  bank2_q <= wdat & `EMW_MASK_BANK; // [R7] [R10]
      if (wr_fire & sel_pins) pins_q  <= wdat & `EMW_MASK_PINS;
    end
  end

  // ----------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------
  wire logic [1:0] w1_size = size_q[`EMW_WINDOW1_SIZE_FIELD_LSB +: 2];
  wire logic [1:0] w2_size = size_q[`EMW_WINDOW2_SIZE_FIELD_LSB +: 2];
  wire logic [2:0] w1_base = base_q[`EMW_W1BASE_LSB +: 3]; // [R4]
  wire logic [2:0] w2_base = base_q[`EMW_W2BASE_LSB +: 3]; // [R3]
  wire emw_pkg::emw_bank_t w1_bank = bank1_q[`EMW_BANK_LSB +: 6]; // [R7]
  wire emw_pkg::emw_bank_t w2_bank = bank2_q[`EMW_BANK_LSB +: 6]; // [R7]

  // ----------------------------------------------------------------------
  // Per-window decode
  // ----------------------------------------------------------------------
  logic               w1_hit;
  logic               w2_hit;
  emw_pkg::emw_bank_t w1_xa;
  emw_pkg::emw_bank_t w2_xa;

  emw_window_decode u_win1 (
    .size_i (w1_size),
    .base_i (w1_base),
    .bank_i (w1_bank),
    .addr_i (cpu_addr_i),
    .hit_o  (w1_hit),
    .xa_o   (w1_xa)
  );

  emw_window_decode u_win2 (
    .size_i (w2_size),
    .base_i (w2_base),
    .bank_i (w2_bank),
    .addr_i (cpu_addr_i),
    .hit_o  (w2_hit),
    .xa_o   (w2_xa)
  );

  // ----------------------------------------------------------------------
  // Priority and line selection
  // ----------------------------------------------------------------------
  wire logic act1 = cpu_access_i & w1_hit;
  wire logic act2 = cpu_access_i & w2_hit & ~act1; // [R11]
  // Outside a window the low lines carry the plain CPU address
  wire emw_pkg::emw_bank_t xa_sel = act1 ? w1_xa :
                                    act2 ? w2_xa :
                                    {3'h0, cpu_addr_i[15:13]}; // [R8] [R14] [R12]
  wire emw_pkg::emw_bank_t xa_pin = xa_sel & pins_q[5:0]; // [R9]

  // Assigned low lines take over the CPU address pins
  logic [2:0] hi_addr;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_hi_addr
      assign hi_addr[gi] = pins_q[gi] ? xa_sel[gi] : cpu_addr_i[13 + gi]; // [R13]
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pin registers; config is registered, so a write shows next access
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cpu_addr_q <= 16'h0000;
      exp_addr_q <= 6'h00;
      hit_q      <= 2'h0;
    end else begin
      cpu_addr_q <= {hi_addr, cpu_addr_i[12:0]}; // [R16]
      exp_addr_q <= xa_pin;                      // [R8]
      hit_q      <= {act2, act1};
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_o             = prdata_q;
  assign pready_o             = pready_q;
  assign pslverr_o            = pslverr_q;
  assign cpu_addr_o           = cpu_addr_q;
  assign exp_addr_o           = exp_addr_q;
  assign exp_line_en_o        = pins_q[5:0];
  assign window_hit_o         = hit_q;
  assign gpsel1_addr_follow_o = size_q[`EMW_FOLLOW1_BIT];
  assign gpsel2_addr_follow_o = size_q[`EMW_FOLLOW2_BIT];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // Disabled size never hits
  a_size_off_quiet: assert property ( // [R1]
    (w1_size == 2'h0) |-> !w1_hit)
    else $error("disabled window 1 reported a hit");

  // Reserved bits of base and bank stay zero
  a_reserved_zero: assert property ( // [R4] [R7] [R15]
    base_q[4] == 1'b0 && base_q[0] == 1'b0 && bank1_q[7] == 1'b0
    && bank1_q[0] == 1'b0 && bank2_q[7] == 1'b0 && bank2_q[0] == 1'b0)
    else $error("reserved register bit set");

  // Any 8K boundary from the base field hits window 1
  a_base_8k_hit: assert property ( // [R5]
    (cpu_access_i && w1_size == 2'h1 && cpu_addr_i[15:13] == w1_base)
    |=> window_hit_o == 2'h1)
    else $error("8K window 1 missed its base");

  // 16K window ignores the lowest base bit
  a_base_16k_hit: assert property ( // [R6]
    (cpu_access_i && w1_size == 2'h2 && cpu_addr_i[15:14] == w1_base[2:1])
    |=> window_hit_o[0])
    else $error("16K window 1 missed its base");

  // Window 2 placed by bits 7:5 when window 1 is off
  a_win2_base: assert property ( // [R3]
    (cpu_access_i && w1_size == 2'h0 && w2_size == 2'h1
     && cpu_addr_i[15:13] == base_q[7:5]) |=> window_hit_o == 2'h2)
    else $error("window 2 missed its base");

  // Overlap goes to window 1
  a_win1_priority: assert property ( // [R11]
    (cpu_access_i && w1_hit && w2_hit) |=> window_hit_o == 2'h1)
    else $error("window 2 won an overlap");

  // Full 8K bank reaches the pins when all lines are assigned
  a_bank_drive: assert property ( // [R8]
    (act1 && w1_size == 2'h1 && pins_q == 8'h3F)
    |=> exp_addr_o == $past(bank1_q[6:1]))
    else $error("bank 1 not driven on expansion lines");

  // 32K uses only four bank bits; low lines follow address
  a_bank_32k_limit: assert property ( // [R2]
    (act1 && w1_size == 2'h3 && w1_base[2:1] == 2'h0 && pins_q == 8'h3F)
    |=> exp_addr_o[1:0] == $past(cpu_addr_i[14:13])
        && exp_addr_o[5:2] == $past(bank1_q[6:3]))
    else $error("32K window bank width wrong");

  // Mid 32K window inverts address 14
  a_mid_invert: assert property ( // [R12]
    (act1 && w1_size == 2'h3 && w1_base[2:1] == 2'h1 && pins_q[1])
    |=> exp_addr_o[1] == !$past(cpu_addr_i[14]))
    else $error("address 14 not inverted in mid window");

  // No access: low lines still show CPU address
  a_idle_follow: assert property ( // [R14] [R13]
    (!cpu_access_i) |=> exp_addr_o == {3'h0, $past(cpu_addr_i[15:13]) & $past(pins_q[2:0])}
                        && cpu_addr_o[15:13] == $past(cpu_addr_i[15:13]))
    else $error("idle lines do not follow CPU address");

  // Unassigned pins never carry expansion data
  a_gpio_gate: assert property ( // [R9]
    (pins_q[5:0] == 6'h00) |=> exp_addr_o == 6'h00)
    else $error("expansion line driven while unassigned");

  // Mid 32K window leaves address 14 true outside any window
  a_mid_outside: assert property ( // [R12]
    (cpu_access_i && !w1_hit && !w2_hit && pins_q[1])
    |=> exp_addr_o[1] == $past(cpu_addr_i[14]))
    else $error("address 14 altered outside any window");

  // Assigned low lines and CPU pins 15:13 carry one value
  a_low_lines_match: assert property ( // [R13]
    (pins_q[2:0] == 3'h7) |=> cpu_addr_o[15:13] == exp_addr_o[2:0])
    else $error("CPU pins 15:13 differ from assigned lines");

  // Full 8K bank of window 2 reaches the pins
  a_bank2_drive: assert property ( // [R8]
    (act2 && w2_size == 2'h1 && pins_q == 8'h3F)
    |=> exp_addr_o == $past(bank2_q[6:1]))
    else $error("bank 2 not driven on expansion lines");

  // Window 2 active where window 1 does not cover
  a_win2_gap: assert property ( // [R11]
    (cpu_access_i && !w1_hit && w2_hit) |=> window_hit_o == 2'h2)
    else $error("window 2 lost an uncovered access");

  // Size write visible three cycles after setup
  a_write_apply: assert property ( // [R16]
    (wr_fire && sel_size) |=> size_q == ($past(pwdata_i[7:0]) & 8'hF3))
    else $error("size write not applied");

  c_overlap: cover property (cpu_access_i && w1_hit && w2_hit);
  c_mid_window: cover property (act1 && w1_size == 2'h3 && w1_base == 3'h2);
  c_bank_write: cover property (wr_fire && sel_bk2);
  c_unmapped: cover property (pslverr_q && pready_q);
  c_win2_8k: cover property (act2 && w2_size == 2'h1);
endmodule // emw_top

// file: verilog/emw_defs.svh
// Register indices, byte addresses, field positions, masks and resets.
// Assumes inclusion by the window banking files only.
`ifndef EMW_DEFS_SVH
`define EMW_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define EMW_IDX_SIZE    8'h56
`define EMW_IDX_BASE    8'h57
`define EMW_IDX_BANK1   8'h58
`define EMW_IDX_BANK2   8'h59
`define EMW_IDX_PINS    8'h5A
`define EMW_IDX_STAT    8'h5B
`define EMW_ADDR(idx)   {2'b00, idx, 2'b00}

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EMW_WINDOW1_SIZE_FIELD_LSB    0
`define EMW_WINDOW2_SIZE_FIELD_LSB    4
`define EMW_FOLLOW1_BIT 6
`define EMW_FOLLOW2_BIT 7
`define EMW_W1BASE_LSB  1
`define EMW_W2BASE_LSB  5
`define EMW_BANK_LSB    1

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define EMW_MASK_SIZE   8'hF3
`define EMW_MASK_BASE   8'hEE
`define EMW_MASK_BANK   8'h7E
`define EMW_MASK_PINS   8'h3F
`define EMW_RST_REG     8'h00

`endif

// file: verilog/emw_pkg.sv
// Types shared by the window banking files.
// Assumes nothing of its surroundings.
package emw_pkg;
  // Window size field encodings
  typedef enum logic [1:0] {
    EMW_OFF = 2'h0,
    EMW_8K  = 2'h1,
    EMW_16K = 2'h2,
    EMW_32K = 2'h3
  } emw_size_e;
  typedef logic [5:0] emw_bank_t;
endpackage

// file: verilog/emw_window_decode.sv
// One address window: hit decode and expansion line value.
// Assumes a registered size, base and bank from the register file.
`timescale 1ns/10ps
module emw_window_decode (
  input  wire logic [1:0]        size_i,
  input  wire logic [2:0]        base_i,
  input  wire emw_pkg::emw_bank_t bank_i,
  input  wire logic [15:0]       addr_i,
  output logic                   hit_o,
  output emw_pkg::emw_bank_t     xa_o
);
  // ----------------------------------------------------------------------
  // Hit decode per size
  // ----------------------------------------------------------------------
  wire logic sz_8k  = (size_i == emw_pkg::EMW_8K);
  wire logic sz_16k = (size_i == emw_pkg::EMW_16K);
  wire logic sz_32k = (size_i == emw_pkg::EMW_32K);
  // Base 010/011 places a 32K window at 0x4000
  wire logic mid32  = ~base_i[2] & base_i[1];
  wire logic hit8   = (addr_i[15:13] == base_i); // [R5]
  wire logic hit16  = (addr_i[15:14] == base_i[2:1]); // [R6]
  wire logic hit32  = mid32 ? (addr_i[15] ^ addr_i[14]) : (addr_i[15] == base_i[2]); // [R6]
  assign hit_o = (sz_8k & hit8) | (sz_16k & hit16) | (sz_32k & hit32);

  // ----------------------------------------------------------------------
  // Line value: in-window address bits replace unused bank bits
  // ----------------------------------------------------------------------
  // Mid window inverts bit 14 so the memory sees one contiguous range
  assign xa_o = sz_16k ? {bank_i[5:1], addr_i[13]} :
                sz_32k ? {bank_i[5:2], addr_i[14] ^ mid32, addr_i[13]} :
                bank_i; // [R2]
endmodule // emw_window_decode

// file: test/emw_paged_mem.sv
// Far-side model: external paged memory seen through the banking block.
// Assumes it is wired to the CPU address pins and the expansion lines.
`timescale 1ns/10ps
module emw_paged_mem (
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [5:0]  exp_addr_i,
  input  wire logic [5:0]  exp_en_i,
  output logic      [18:0] phys_o
);
  // Memory A15:13 come from the CPU pins, which carry the low lines
  // Lines 5:3 left as GPIO are pulled low at the memory, never last value
  assign phys_o = {exp_addr_i[5:3] & exp_en_i[5:3], cpu_addr_i};
endmodule // emw_paged_mem

// file: test/emw_top_tb.sv
// Self-checking bench for the window banking block over APB.
// Assumes a 40 MHz clock and the paged memory model on the far side.
`timescale 1ns/10ps
`include "emw_defs.svh"
module emw_top_tb;
  localparam logic [11:0] SZ = `EMW_ADDR(`EMW_IDX_SIZE);
  localparam logic [11:0] BS = `EMW_ADDR(`EMW_IDX_BASE);
  localparam logic [11:0] B1 = `EMW_ADDR(`EMW_IDX_BANK1);
  localparam logic [11:0] B2 = `EMW_ADDR(`EMW_IDX_BANK2);
  localparam logic [11:0] PN = `EMW_ADDR(`EMW_IDX_PINS);
  localparam logic [11:0] ST = `EMW_ADDR(`EMW_IDX_STAT);
  logic        fol1, fol2;
  logic        clk_i    = 1'b0;
  logic        srst_i   = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [15:0] cpu_addr = 16'h0000;
  logic        cpu_acc  = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic [15:0] addr_out;
  logic [5:0]  exp_addr, exp_en;
  logic [1:0]  hit;
  logic [18:0] phys;
  int          n_fail = 0;
  int          checks_done = 0;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;
  emw_top dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cpu_addr_i(cpu_addr),
    .cpu_access_i(cpu_acc), .cpu_addr_o(addr_out), .exp_addr_o(exp_addr),
    .exp_line_en_o(exp_en), .window_hit_o(hit), .gpsel1_addr_follow_o(fol1),
    .gpsel2_addr_follow_o(fol2));
  emw_paged_mem mem (.cpu_addr_i(addr_out), .exp_addr_i(exp_addr), .exp_en_i(exp_en),
    .phys_o(phys));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge: next call never reassigns psel in this step
    @(posedge clk_i);
    if (n >= 20) begin
      n_fail++;
      results();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        er;
    apb(1'b1, a, d, r, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic ee);
    logic [31:0] r;
    logic        er;
    apb(1'b0, a, 8'h00, r, er);
    chk(r, {24'h0, e});
    chk({31'h0, er}, {31'h0, ee});
  endtask

  // Present one CPU access, judge the memory address and hits two cycles on
  task automatic cpu(input logic [15:0] a, input logic acc, input logic [18:0] ep,
                     input logic [1:0] eh);
    cpu_addr <= a;
    cpu_acc  <= acc;
    repeat (2) @(posedge clk_i);
    chk({13'h0, phys}, {13'h0, ep});
    chk({30'h0, hit}, {30'h0, eh});
    chk({29'h0, exp_addr[2:0]}, {29'h0, ep[15:13] & exp_en[2:0]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(SZ, 8'h00, 1'b0);
    rd(BS, 8'h00, 1'b0);
    rd(B1, 8'h00, 1'b0);
    rd(B2, 8'h00, 1'b0);
    cpu(16'h2345, 1'b1, 19'h02345, 2'b00);
  endtask

  // Reserved bits must drop; unmapped place refused
  task automatic t_masks();
    wr(SZ, 8'hFF);
    rd(SZ, 8'hF3, 1'b0);
    chk({30'h0, fol2, fol1}, 32'h0000_0003);
    wr(BS, 8'hFF);
    rd(BS, 8'hEE, 1'b0);
    wr(B1, 8'hFF);
    rd(B1, 8'h7E, 1'b0);
    wr(B2, 8'hFF);
    rd(B2, 8'h7E, 1'b0);
    wr(12'h100, 8'hFF);
    rd(12'h100, 8'h00, 1'b1);
  endtask

  // 8K window 1 at the top boundary, all six bank lines
  task automatic t_8k();
    wr(PN, 8'h3F);
    wr(SZ, 8'h01);
    wr(BS, 8'h0E);
    wr(B1, 8'h54);
    cpu(16'hE001, 1'b1, 19'h54001, 2'b01);
    cpu(16'hDFFF, 1'b1, 19'h0DFFF, 2'b00);
    cpu(16'hE001, 1'b0, 19'h0E001, 2'b00);
  endtask

  // 16K window 2, base LSB ignored
  task automatic t_16k();
    wr(SZ, 8'h20);
    wr(BS, 8'h60);
    wr(B2, 8'h7E);
    cpu(16'h4001, 1'b1, 19'h7C001, 2'b10);
    cpu(16'h7FFF, 1'b1, 19'h7FFFF, 2'b10);
    cpu(16'h3FFF, 1'b1, 19'h03FFF, 2'b00);
  endtask

  // 32K window 1 at 0x4000 flips address 14 inside only
  task automatic t_32k();
    wr(SZ, 8'h03);
    wr(BS, 8'h04);
    wr(B1, 8'h2A);
    cpu(16'h4123, 1'b1, 19'h28123, 2'b01);
    cpu(16'hBFFF, 1'b1, 19'h2FFFF, 2'b01);
    cpu(16'hC000, 1'b1, 19'h0C000, 2'b00);
  endtask

  // Overlap, then pin assignment gating
  task automatic t_overlap();
    wr(SZ, 8'h21);
    wr(BS, 8'h64);
    wr(B1, 8'h02);
    cpu(16'h4000, 1'b1, 19'h02000, 2'b01);
    cpu(16'h6000, 1'b1, 19'h7E000, 2'b10);
    wr(PN, 8'h07);
    chk({26'h0, exp_en}, 32'h0000_0007);
    cpu(16'h6000, 1'b1, 19'h0E000, 2'b10);
    wr(PN, 8'h00);
    cpu(16'h4000, 1'b1, 19'h04000, 2'b01);
    rd(ST, 8'h01, 1'b0);
  endtask

  // Window 2 at 8K, then window 1 at 16K and at 32K from zero
  task automatic t_more();
    wr(PN, 8'h3F);
    wr(SZ, 8'h10);
    wr(BS, 8'hA0);
    cpu(16'hA010, 1'b1, 19'h7E010, 2'b10);
    wr(SZ, 8'h02);
    wr(BS, 8'h06);
    wr(B1, 8'h0A);
    cpu(16'h5234, 1'b1, 19'h09234, 2'b01);
    wr(SZ, 8'h03);
    wr(BS, 8'h02);
    cpu(16'h7ABC, 1'b1, 19'h0FABC, 2'b01);
    cpu(16'h8000, 1'b1, 19'h08000, 2'b00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_masks();
    t_8k();
    t_16k();
    t_32k();
    t_overlap();
    t_more();
    results();
  end
endmodule // emw_top_tb
